// ### design/clcis_pkg.sv
// package for the logic cell input stage: register map, field layout,
// reset values, bus answers and the structs that carry the source signals.
// assumes one 100 MHz core clock shared by the bus and all on-chip sources.
package clcis_pkg;

    // register byte addresses, one aligned word each
    localparam logic [31:0] CLCIS_ADDR_SEL    = 32'h0000_0000;
    localparam logic [31:0] CLCIS_ADDR_GLSL   = 32'h0000_0004;
    localparam logic [31:0] CLCIS_ADDR_POL    = 32'h0000_0008;
    localparam logic [31:0] CLCIS_ADDR_STATUS = 32'h0000_000C;

    // values after reset
    localparam logic [15:0] CLCIS_SEL_RESET   = 16'h0000;
    localparam logic [15:0] CLCIS_GLSL_RESET  = 16'h0000;
    localparam logic [1:0]  CLCIS_POL_RESET   = 2'h0;

    // selector fields sit on a four bit stride, three bits wide
    localparam int          CLCIS_FIELD_STRIDE = 4;
    localparam logic [15:0] CLCIS_SEL_IMPL     = 16'h7777;
    // gate 1 enables in the low byte, gate 2 in the high byte
    localparam int          CLCIS_GATE1_LSB    = 0;
    localparam int          CLCIS_GATE2_LSB    = 8;

    // bus answers
    localparam logic [1:0]  CLCIS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  CLCIS_RESP_DECERR = 2'h3;

    // signals that arrive from pins or foreign clocks, synchronised inside
    typedef struct packed {
        logic cell_input_pin_a;
        logic cell_input_pin_b;
        logic cell_input_pin_c;
        logic cell_input_pin_d;
        logic instruction_clock;
        logic internal_slow_rc_clock;
        logic reference_clock_output;
    } clcis_pins_t;

    // peripheral outputs of the core that owns this cell, on aclk
    typedef struct packed {
        logic cell1_out;
        logic cell2_out;
        logic cell3_out;
        logic cell4_out;
        logic [4:1] ccu_aux;
        logic [4:1] ccu_compare_output;
        logic [4:3] ccu_event_flag;
        logic uart1_tx;
        logic uart1_rx;
        logic spi1_serial_data_out;
        logic spi1_serial_data_in;
        logic pwm_event_a;
    } clcis_own_t;

    // signals shared between the two cores, on aclk
    typedef struct packed {
        logic main_cell2_out;
        logic sec_cell2_out;
        logic main_cmp1;
        logic sec_cmp1;
        logic sec_cmp2;
        logic sec_cmp3;
    } clcis_shared_t;

endpackage

// ### design/clcis_input_select.sv
// input select stage of one configurable logic cell: four source
// multiplexers, true/inverted gate enables and gates 1 and 2.
// assumes an axi4-lite master on aclk; own and shared inputs are on aclk,
// pin inputs are asynchronous and synchronised here.
module clcis_input_select
    import clcis_pkg::*;
#(
    parameter bit IS_SECONDARY = 1'b0
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire clcis_pins_t   pins,
    input  wire clcis_own_t    own,
    input  wire clcis_shared_t shared,
    output logic               gate1_out,
    output logic               gate2_out
);

    // merge a 16-bit register with byte-enabled write data
    function automatic logic [15:0] apply_strb(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // or of the enabled true/inverted terms, then polarity
    // true and inverted copy per source
    function automatic logic gate_eval(input logic [7:0] en,
                                       input logic [3:0] src,
                                       input logic       pol);
        logic [7:0] terms;
        terms = {src[3], ~src[3], src[2], ~src[2], src[1], ~src[1], src[0], ~src[0]};
        return (|(en & terms)) ^ pol;
    endfunction

    logic [15:0]  sel_reg;
    logic [15:0]  glsl_reg;
    logic [1:0]   pol_reg;
    clcis_pins_t  pin_meta_reg;
    clcis_pins_t  pin_sync_reg;
    logic         aw_held_reg;
    logic [31:0]  aw_addr_reg;
    logic         w_held_reg;
    logic [31:0]  w_data_reg;
    logic [3:0]   w_strb_reg;
    logic         bvalid_reg;
    logic [1:0]   bresp_reg;
    logic         rvalid_reg;
    logic [31:0]  rdata_reg;
    logic [1:0]   rresp_reg;

    // pins and foreign clocks cross through two flops before any use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pins;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire [2:0] code1 = sel_reg[0*CLCIS_FIELD_STRIDE +: 3];
    wire [2:0] code2 = sel_reg[1*CLCIS_FIELD_STRIDE +: 3];
    wire [2:0] code3 = sel_reg[2*CLCIS_FIELD_STRIDE +: 3];
    wire [2:0] code4 = sel_reg[3*CLCIS_FIELD_STRIDE +: 3];

    // candidate vectors, index equals selector code
    // source 1 candidates
    // same order, wired to the owning core
    wire [7:0] cand1 = {own.ccu_aux[4], own.ccu_aux[2], shared.sec_cmp3,
                        pin_sync_reg.reference_clock_output,
                        pin_sync_reg.internal_slow_rc_clock, own.cell3_out,
                        pin_sync_reg.instruction_clock,
                        pin_sync_reg.cell_input_pin_a};
    // cross-core cell 2 swaps with the instance
    wire       other_cell2 = IS_SECONDARY ? shared.main_cell2_out : shared.sec_cell2_out;
    // source 2 candidates, 100 and 101 reserved
    wire [7:0] cand2 = {own.ccu_compare_output[2], own.ccu_compare_output[1], 1'b0, 1'b0,
                        own.uart1_tx, shared.main_cmp1, other_cell2,
                        pin_sync_reg.cell_input_pin_b};
    // secondary takes compare event flags on 110/111
    wire [1:0] ccu34 = IS_SECONDARY ? own.ccu_event_flag[4:3] : own.ccu_compare_output[4:3];
    wire [7:0] cand3 = {ccu34, own.cell4_out, own.uart1_rx, own.spi1_serial_data_out,
                        shared.sec_cmp1, own.cell1_out, pin_sync_reg.cell_input_pin_c};
    // same order, wired to the owning core
    // spi terms are only meaningful when remapped by software
    wire [7:0] cand4 = {own.ccu_aux[3], own.ccu_aux[1], pin_sync_reg.cell_input_pin_d, 1'b0,
                        own.spi1_serial_data_in, shared.sec_cmp2, own.cell2_out,
                        own.pwm_event_a};
    wire [3:0] src = {cand4[code4], cand3[code3], cand2[code2], cand1[code1]};

    // gates; reserved codes feed a steady zero so an empty pick cannot float
    // byte per gate
    wire [7:0] en_g1 = glsl_reg[CLCIS_GATE1_LSB +: 8];
    wire [7:0] en_g2 = glsl_reg[CLCIS_GATE2_LSB +: 8];
    // or of enabled terms, true and inverted
    // combinational path to the function stage
    assign gate1_out = gate_eval(en_g1, src, pol_reg[0]);
    assign gate2_out = gate_eval(en_g2, src, pol_reg[1]);

    // write channel: address and data taken independently, one write at a time
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    wire   aw_take = s_axi_awvalid && s_axi_awready;
    wire   w_take  = s_axi_wvalid && s_axi_wready;
    wire   wr_en   = aw_held_reg && w_held_reg;
    wire   wr_sel  = wr_en && (aw_addr_reg == CLCIS_ADDR_SEL);
    wire   wr_glsl = wr_en && (aw_addr_reg == CLCIS_ADDR_GLSL);
    wire   wr_pol  = wr_en && (aw_addr_reg == CLCIS_ADDR_POL);
    wire   wr_hit  = wr_sel || wr_glsl || wr_pol || (aw_addr_reg == CLCIS_ADDR_STATUS);

    wire [15:0] sel_next  = apply_strb(sel_reg, w_data_reg, w_strb_reg) & CLCIS_SEL_IMPL;
    wire [15:0] glsl_next = apply_strb(glsl_reg, w_data_reg, w_strb_reg);
    wire [1:0]  pol_next  = w_strb_reg[0] ? w_data_reg[1:0] : pol_reg;

    // address and data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0000_0000;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[31:2], 2'b00};
            end else if (wr_en) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_en) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // write response; the status word is read-only and a write is ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= CLCIS_RESP_OKAY;
        end else if (wr_en) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? CLCIS_RESP_OKAY : CLCIS_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // configuration registers
    // gap bits masked, reset to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg  <= CLCIS_SEL_RESET;
            glsl_reg <= CLCIS_GLSL_RESET;
            pol_reg  <= CLCIS_POL_RESET;
        end else begin
            if (wr_sel) begin
                sel_reg <= sel_next;
            end
            if (wr_glsl) begin
                glsl_reg <= glsl_next;
            end
            if (wr_pol) begin
                pol_reg <= pol_next;
            end
        end
    end

    // read decode; status shows live sources and gate results
    wire [31:0] rd_addr = {s_axi_araddr[31:2], 2'b00};
    wire        rd_hit  = (rd_addr == CLCIS_ADDR_SEL) || (rd_addr == CLCIS_ADDR_GLSL) ||
                          (rd_addr == CLCIS_ADDR_POL) || (rd_addr == CLCIS_ADDR_STATUS);
    wire [31:0] rd_word = (rd_addr == CLCIS_ADDR_SEL)  ? {16'h0000, sel_reg} :
                          (rd_addr == CLCIS_ADDR_GLSL) ? {16'h0000, glsl_reg} :
                          (rd_addr == CLCIS_ADDR_POL)  ? {30'h0000_0000, pol_reg} :
                          (rd_addr == CLCIS_ADDR_STATUS) ?
                          {26'h000_0000, src, gate2_out, gate1_out} : 32'h0000_0000;
    assign s_axi_arready = !rvalid_reg;
    wire   ar_take = s_axi_arvalid && s_axi_arready;

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= CLCIS_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_hit ? CLCIS_RESP_OKAY : CLCIS_RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // checks on the selection, gate and bus response paths
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sel_write;
        wr_sel && (w_strb_reg[1:0] == 2'b11) |=>
            sel_reg == ($past(w_data_reg[15:0]) & CLCIS_SEL_IMPL);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector write lost");

    property p_sel_gaps;
        s_axi_rvalid && (rdata_reg[15:0] == sel_reg) && (sel_reg != 16'h0000) |->
            (rdata_reg[15] | rdata_reg[11] | rdata_reg[7] | rdata_reg[3]) == 1'b0;
    endproperty
    a_sel_gaps: assert property (p_sel_gaps) else $error("gap bit set in select");

    property p_pin_a_path;
        (code1 == 3'b000) [*3] |-> src[0] == $past(pins.cell_input_pin_a, 2);
    endproperty
    a_pin_a_path: assert property (p_pin_a_path) else $error("pin a path wrong");

    property p_uart_tx;
        code2 == 3'b011 |-> src[1] == own.uart1_tx;
    endproperty
    a_uart_tx: assert property (p_uart_tx) else $error("source 2 uart tx wrong");

    property p_cross_cell2;
        code2 == 3'b001 |->
            src[1] == (IS_SECONDARY ? shared.main_cell2_out : shared.sec_cell2_out);
    endproperty
    a_cross_cell2: assert property (p_cross_cell2) else $error("cross cell 2 wrong");

    property p_src3_top;
        code3 == 3'b111 |->
            src[2] == (IS_SECONDARY ? own.ccu_event_flag[4] : own.ccu_compare_output[4]);
    endproperty
    a_src3_top: assert property (p_src3_top) else $error("source 3 code 7 wrong");

    property p_src4_reserved;
        code4 == 3'b100 |-> src[3] == 1'b0;
    endproperty
    a_src4_reserved: assert property (p_src4_reserved) else $error("reserved not zero");

    property p_empty_gate;
        en_g1 == 8'h00 |-> gate1_out == pol_reg[0];
    endproperty
    a_empty_gate: assert property (p_empty_gate) else $error("empty gate not polarity");

    property p_true_only;
        (en_g1 == 8'h02) && !pol_reg[0] |-> gate1_out == src[0];
    endproperty
    a_true_only: assert property (p_true_only) else $error("true enable wrong");

    property p_inv_pol;
        (en_g1 == 8'h02) && pol_reg[0] |-> gate1_out == !src[0];
    endproperty
    a_inv_pol: assert property (p_inv_pol) else $error("inverted or polarity wrong");

    property p_both_terms;
        (en_g1 == 8'hFF) && !pol_reg[0] |-> gate1_out == 1'b1;
    endproperty
    a_both_terms: assert property (p_both_terms) else $error("true plus inverted not one");

    property p_gate2_byte;
        (en_g2 == 8'h40) && !pol_reg[1] |-> gate2_out == !src[3];
    endproperty
    a_gate2_byte: assert property (p_gate2_byte) else $error("gate 2 byte order wrong");

    property p_write_resp;
        wr_en |=> s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");

    property p_read_resp;
        ar_take |=> s_axi_rvalid ##0 (s_axi_rdata == $past(rd_word));
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read answer wrong");

    c_sel_write:  cover property (wr_sel);
    c_gate1_high: cover property ((en_g1 != 8'h00) && gate1_out);
    c_gate2_inv:  cover property (pol_reg[1] && (en_g2 != 8'h00));
    c_decerr:     cover property (s_axi_rvalid && (s_axi_rresp == CLCIS_RESP_DECERR));

endmodule

// ### test/clcis_src_model.sv
// far-side model: on-chip peripheral levels and the cell input pins.
// assumes the bench sets one 32-bit level word: pins at the top,
// own peripheral levels in the middle, shared cross-core levels lowest.
module clcis_src_model
    import clcis_pkg::*;
(
    input  wire logic [31:0] level,
    output clcis_pins_t      pins,
    output clcis_own_t       own,
    output clcis_shared_t    shared
);
    timeunit 1ns;
    timeprecision 100ps;

    // spi lines driven
    // spi levels move even when not remapped; choosing them is software's call
    assign {pins, own, shared} = level;
endmodule

// ### test/tb.sv
// self-checking bench for the logic cell input select stage.
// assumes a main and a secondary instance on one axi4-lite master;
// only the main instance's bus answers are watched.
module tb import clcis_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [31:0]   s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, level = '0;
    logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0]    s_axi_wstrb = 4'hf;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic [31:0]   s_axi_rdata;
    logic          gate1_out, gate2_out, g1s, g2s;
    clcis_pins_t   pins;
    clcis_own_t    own;
    clcis_shared_t shared;
    int            err_count = 0;
    int            cmp_count = 0;
    int            cycles = 0;
    // level bit of each code, per source; -1 is reserved
    int            map_m [4][8] = '{'{31, 27, 22, 26, 25, 0, 18, 20}, '{30, 4, 3, 10, -1, -1, 13, 14},
                                    '{29, 24, 2, 8, 9, 21, 15, 16}, '{6, 23, 1, 7, -1, 28, 17, 19}};
    int            map_s [4][8] = '{'{31, 27, 22, 26, 25, 0, 18, 20}, '{30, 5, 3, 10, -1, -1, 13, 14},
                                    '{29, 24, 2, 8, 9, 21, 11, 12}, '{6, 23, 1, 7, -1, 28, 17, 19}};

    clcis_input_select #(.IS_SECONDARY(1'b0)) dut (.*);
    clcis_input_select #(.IS_SECONDARY(1'b1)) dut_sec (.*, .s_axi_awready(), .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .gate1_out(g1s), .gate2_out(g2s));
    clcis_src_model src (.level(level), .pins(pins), .own(own), .shared(shared));

    // 100 MHz core clock
    always #5 aclk = ~aclk;

    // cycle ceiling stops a hung handshake
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    // readies are sampled at the falling edge, taken at the next rising one
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic at, wt, bt;
        bt = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bt) begin
            @(negedge aclk);
            at = s_axi_awvalid && s_axi_awready;
            wt = s_axi_wvalid && s_axi_wready;
            bt = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (at) s_axi_awvalid <= 1'b0;
            if (wt) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic at, rt;
        rt = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rt) begin
            @(negedge aclk);
            at = s_axi_arvalid && s_axi_arready;
            rt = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (at) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(32'(r), 32'(er));
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d, e);
        chk(32'(r), 32'(er));
    endtask

    // pins need two edges through the synchronisers, four is ample
    task automatic gate_chk(input logic [31:0] lv, input logic [3:0] e);
        level <= lv;
        repeat (4) @(posedge aclk);
        chk(32'({gate1_out, gate2_out, g1s, g2s}), 32'(e));
    endtask

    function automatic logic pick(input logic [31:0] lv, input int i);
        return (i < 0) ? 1'b0 : lv[i];
    endfunction

    function automatic logic [31:0] mask(input int i);
        return (i < 0) ? 32'h0000_0000 : 32'h0000_0001 << i;
    endfunction

    // main sequence: registers, gate forms, then every code of every source
    initial begin
        logic [31:0] lv [4];
        logic        pm, ps;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(CLCIS_ADDR_SEL, 32'h0000_0000, CLCIS_RESP_OKAY);
        rd_chk(CLCIS_ADDR_GLSL, 32'h0000_0000, CLCIS_RESP_OKAY);
        wr_chk(CLCIS_ADDR_SEL, 32'h0000_ffff, CLCIS_RESP_OKAY);
        rd_chk(CLCIS_ADDR_SEL, 32'h0000_7777, CLCIS_RESP_OKAY);
        wr_chk(CLCIS_ADDR_GLSL, 32'h0000_a55a, CLCIS_RESP_OKAY);
        rd_chk(CLCIS_ADDR_GLSL, 32'h0000_a55a, CLCIS_RESP_OKAY);
        wr_chk(32'h0000_0010, 32'h0000_ffff, CLCIS_RESP_DECERR);
        rd_chk(32'h0000_0010, 32'h0000_0000, CLCIS_RESP_DECERR);
        wr_chk(CLCIS_ADDR_GLSL, 32'h0000_0000, CLCIS_RESP_OKAY);
        gate_chk(32'hffff_ffff, 4'h0);
        wr_chk(CLCIS_ADDR_POL, 32'h0000_0003, CLCIS_RESP_OKAY);
        gate_chk(32'hffff_ffff, 4'hf);
        rd_chk(CLCIS_ADDR_STATUS, 32'h0000_003f, CLCIS_RESP_OKAY);
        rd_chk(CLCIS_ADDR_POL, 32'h0000_0003, CLCIS_RESP_OKAY);
        wr_chk(CLCIS_ADDR_STATUS, 32'h0000_0000, CLCIS_RESP_OKAY);
        // only the upper lane is written, the lower selectors stay
        s_axi_wstrb <= 4'h2;
        wr_chk(CLCIS_ADDR_SEL, 32'h0000_0000, CLCIS_RESP_OKAY);
        rd_chk(CLCIS_ADDR_SEL, 32'h0000_0077, CLCIS_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        wr_chk(CLCIS_ADDR_SEL, 32'h0000_0000, CLCIS_RESP_OKAY);
        wr_chk(CLCIS_ADDR_GLSL, 32'h0000_0002, CLCIS_RESP_OKAY);
        gate_chk(32'h8000_0000, 4'h5);
        wr_chk(CLCIS_ADDR_POL, 32'h0000_0000, CLCIS_RESP_OKAY);
        wr_chk(CLCIS_ADDR_GLSL, 32'h0000_00ff, CLCIS_RESP_OKAY);
        gate_chk(32'h0000_0000, 4'ha);
        // gate 1 takes the true copy, gate 2 the inverted copy
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 8; c++) begin
                wr_chk(CLCIS_ADDR_SEL, 32'(c) << (4 * s), CLCIS_RESP_OKAY);
                wr_chk(CLCIS_ADDR_GLSL, (32'h0000_0102 << (2 * s)), CLCIS_RESP_OKAY);
                lv[0] = 32'h0000_0000;
                lv[1] = mask(map_m[s][c]);
                lv[2] = mask(map_s[s][c]);
                lv[3] = ~lv[1];
                for (int k = 0; k < 4; k++) begin
                    pm = pick(lv[k], map_m[s][c]);
                    ps = pick(lv[k], map_s[s][c]);
                    gate_chk(lv[k], {pm, !pm, ps, !ps});
                end
            end
        end
        // a second reset in mid-run clears every setting
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(CLCIS_ADDR_SEL, 32'h0000_0000, CLCIS_RESP_OKAY);
        gate_chk(32'hffff_ffff, 4'h0);
        final_report();
    end
endmodule
